// ===== ocps_defines.vh
// Offsets, field positions, reset values and codes of the command and page select block
`ifndef OCPS_DEFINES_VH
`define OCPS_DEFINES_VH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 * index)
// ----------------------------------------------------------------
`define OCPS_IDX_SECURITY_KEY 16'h4008
`define OCPS_IDX_NV_MEMORY_COMMAND_CONTROL 16'h400A
`define OCPS_IDX_STATUS 16'h4010
`define OCPS_ADDR_W 20
`define OCPS_ADDR_SECURITY_KEY 20'h10020
`define OCPS_ADDR_CONTROL 20'h10028
`define OCPS_ADDR_STATUS 20'h10040

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define OCPS_BIT_TARGET 13
`define OCPS_BIT_VERIFY 10
`define OCPS_BIT_WRITE 9
`define OCPS_BIT_READ 8
`define OCPS_MARGIN_HI 7
`define OCPS_MARGIN_LO 6
`define OCPS_BIT_ALL_PAGES 5
`define OCPS_PAGE_HI 1
`define OCPS_PAGE_LO 0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define OCPS_ST_BUSY 0
`define OCPS_ST_REJECT 1
`define OCPS_ST_FAIL 2
`define OCPS_ST_UNLOCKED 3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define OCPS_UNLOCK_KEY 16'h9716
`define OCPS_KEY_RESET 16'h0000
`define OCPS_TARGET_RESET 1'b1
`define OCPS_MARGIN_RESET 2'h0
`define OCPS_PAGE_RESET 2'h0
`define OCPS_MARGIN_RESERVED 2'h1
`define OCPS_PAGE_RESERVED 2'h3
`define OCPS_CFG_PAGE_BASE 3'h2
`define OCPS_OP_NONE 2'h0
`define OCPS_OP_READ 2'h1
`define OCPS_OP_WRITE 2'h2
`define OCPS_OP_VERIFY 2'h3
`define OCPS_RESP_OKAY 2'h0
`define OCPS_RESP_SLVERR 2'h2

`endif

// ===== ocps_top.v
// Command, margin and page select register block with AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ocps_defines.vh"

module ocps_top
(
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [`OCPS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`OCPS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg mem_req,
    output reg [1:0] mem_op,
    output reg config_image_memory,
    output reg all_pages_select,
    output reg [2:0] mem_page,
    output reg [1:0] read_margin_select,
    input wire mem_done,
    input wire mem_fail
);

    // ----------------------------------------------------------------
    // State codes
    // ----------------------------------------------------------------
    localparam S_IDLE = 1'b0;
    localparam S_WAIT = 1'b1;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg state;
    reg [15:0] security_key;
    reg target_array;
    reg [1:0] margin;
    reg all_pages;
    reg [1:0] page;
    reg [1:0] active_op;
    reg reject_flag;
    reg fail_flag;
    reg aw_held;
    reg w_held;
    reg [`OCPS_ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    wire unlocked = (security_key == `OCPS_UNLOCK_KEY);
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_key = do_write && (aw_addr == `OCPS_ADDR_SECURITY_KEY);
    wire wr_ctl = do_write && (aw_addr == `OCPS_ADDR_CONTROL);
    wire wr_sts = do_write && (aw_addr == `OCPS_ADDR_STATUS) && w_strb[0];
    wire wr_hit = wr_key || wr_ctl || (do_write && (aw_addr == `OCPS_ADDR_STATUS));
    wire lo_lane = wr_ctl && w_strb[0];
    wire hi_lane = wr_ctl && w_strb[1] && unlocked;

    // Field values as they stand after this write
    wire [1:0] new_margin = lo_lane && unlocked ?
        w_data[`OCPS_MARGIN_HI:`OCPS_MARGIN_LO] : margin;
    wire new_all = lo_lane ? w_data[`OCPS_BIT_ALL_PAGES] : all_pages;
    wire [1:0] new_page = lo_lane ? w_data[`OCPS_PAGE_HI:`OCPS_PAGE_LO] : page;
    wire new_target = hi_lane ? w_data[`OCPS_BIT_TARGET] : target_array;

    // Command decode; a zero command bit does nothing
    reg [1:0] req_op;
    always @*
    begin
        req_op = `OCPS_OP_NONE;
        if (hi_lane && w_data[`OCPS_BIT_READ])
            req_op = `OCPS_OP_READ;
        else if (hi_lane && w_data[`OCPS_BIT_VERIFY])
            req_op = `OCPS_OP_VERIFY;
        else if (hi_lane && w_data[`OCPS_BIT_WRITE])
            req_op = `OCPS_OP_WRITE;
    end

    // Reserved margin blocks a read or verify; reserved page blocks an image access without all pages
    wire margin_bad = (new_margin == `OCPS_MARGIN_RESERVED) &&
        (req_op == `OCPS_OP_READ || req_op == `OCPS_OP_VERIFY);
    wire page_bad = !new_target && !new_all &&
        (new_page == `OCPS_PAGE_RESERVED);
    wire cmd_seen = (req_op != `OCPS_OP_NONE) && (state == S_IDLE);
    wire launch = cmd_seen && !margin_bad && !page_bad;
    wire rejected = cmd_seen && (margin_bad || page_bad);

    // Page mapping per target
    wire [2:0] mapped_page = new_target ? {1'b0, new_page} :
        ({1'b0, new_page} + `OCPS_CFG_PAGE_BASE);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire [15:0] ctl_view = {2'b00, target_array, 2'b00,
        active_op == `OCPS_OP_VERIFY, active_op == `OCPS_OP_WRITE,
        active_op == `OCPS_OP_READ, margin, all_pages, 3'b000, page};
    wire [15:0] sts_view = {12'h000, unlocked, fail_flag, reject_flag, state};
    reg [31:0] rd_word;
    reg rd_hit;
    always @*
    begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `OCPS_ADDR_SECURITY_KEY: rd_word = {16'h0000, security_key};
            `OCPS_ADDR_CONTROL: rd_word = {16'h0000, ctl_view};
            `OCPS_ADDR_STATUS: rd_word = {16'h0000, sts_view};
            default: rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // AXI4-Lite channels
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OCPS_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OCPS_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {`OCPS_ADDR_W{1'b0}};
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `OCPS_RESP_OKAY : `OCPS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `OCPS_RESP_OKAY : `OCPS_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers and command sequencer
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= S_IDLE;
            security_key <= `OCPS_KEY_RESET;
            target_array <= `OCPS_TARGET_RESET;
            margin <= `OCPS_MARGIN_RESET;
            all_pages <= 1'b0;
            page <= `OCPS_PAGE_RESET;
            active_op <= `OCPS_OP_NONE;
            reject_flag <= 1'b0;
            fail_flag <= 1'b0;
            mem_req <= 1'b0;
            mem_op <= `OCPS_OP_NONE;
            config_image_memory <= 1'b0;
            all_pages_select <= 1'b0;
            mem_page <= 3'h0;
            read_margin_select <= `OCPS_MARGIN_RESET;
        end
        else if (ce)
        begin
            mem_req <= 1'b0;
            if (wr_key)
            begin
                if (w_strb[0])
                    security_key[7:0] <= w_data[7:0];
                if (w_strb[1])
                    security_key[15:8] <= w_data[15:8];
            end
            // Selections are frozen while a command is running
            if (state == S_IDLE)
            begin
                margin <= new_margin;
                all_pages <= new_all;
                page <= new_page;
                target_array <= new_target;
            end
            // Sticky flags: a new event wins over a clear
            if (wr_sts && w_data[`OCPS_ST_REJECT])
                reject_flag <= 1'b0;
            if (wr_sts && w_data[`OCPS_ST_FAIL])
                fail_flag <= 1'b0;
            if (rejected)
                reject_flag <= 1'b1;
            case (state)
                S_IDLE:
                begin
                    if (launch)
                    begin
                        state <= S_WAIT;
                        active_op <= req_op;
                        mem_req <= 1'b1;
                        mem_op <= req_op;
                        config_image_memory <= !new_target;
                        all_pages_select <= new_all;
                        mem_page <= mapped_page;
                        read_margin_select <= new_margin;
                    end
                end
                S_WAIT:
                begin
                    if (mem_done)
                    begin
                        state <= S_IDLE;
                        active_op <= `OCPS_OP_NONE;
                        if (mem_fail)
                            fail_flag <= 1'b1;
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // ocps_top
`default_nettype wire

// ===== ocps_checker_sva.sv
// Assertion checker for the command and page select block
`timescale 1ns/1ps
`default_nettype none
module ocps_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic mem_req,
    input wire logic [1:0] mem_op,
    input wire logic config_image_memory,
    input wire logic all_pages_select,
    input wire logic [2:0] mem_page,
    input wire logic [1:0] read_margin_select
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence single_req;
        mem_req && !all_pages_select;
    endsequence
    req_pulse_a: assert property (mem_req |=> !mem_req)
        else $error("access request held too long");
    req_resp_a: assert property (mem_req |-> $rose(s_axi_bvalid))
        else $error("access request without write response");
    op_known_a: assert property (mem_req |-> mem_op != 2'h0)
        else $error("access request with no operation");
    margin_ok_a: assert property (mem_req && mem_op != 2'h2 |-> read_margin_select != 2'h1)
        else $error("access with reserved margin");
    array_page_a: assert property (single_req and !config_image_memory |-> mem_page <= 3'h3)
        else $error("array page out of range");
    image_page_a: assert property (single_req and config_image_memory |-> mem_page inside {[2:4]})
        else $error("image page out of range");
    op_hold_a: assert property (!mem_req |-> $stable(mem_op))
        else $error("operation changed without request");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule // ocps_checker
bind ocps_top ocps_checker ocps_checker_i (.clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .mem_req(mem_req), .mem_op(mem_op),
    .config_image_memory(config_image_memory), .all_pages_select(all_pages_select),
    .mem_page(mem_page), .read_margin_select(read_margin_select));
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the command and page select block
`timescale 1ns/1ps
`default_nettype none
`include "ocps_defines.vh"
`define CHK(a, e) check_v(32'(a), 32'(e))
module testbench;
    // ------------------------------------------------
    // Signals and harness
    // ------------------------------------------------
    logic clk = 1'h0, rst = 1'h1, ce = 1'h1, mem_done = 1'h0, mem_fail = 1'h0;
    logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, mem_op, read_margin_select, rs;
    logic mem_req, config_image_memory, all_pages_select;
    logic [2:0] mem_page;
    logic [8:0] cap = 9'h0;
    logic slow_b = 1'h0;
    int n_errors = 0, total_checks = 0, n_req = 0;
    ocps_top ocps_top_i (.clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_op(mem_op),
        .config_image_memory(config_image_memory), .all_pages_select(all_pages_select),
        .mem_page(mem_page), .read_margin_select(read_margin_select),
        .mem_done(mem_done), .mem_fail(mem_fail));
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Memory answers one cycle after each request; requests are recorded
    always @(posedge clk)
    begin
        mem_done <= mem_req;
        if (mem_req)
        begin
            n_req <= n_req + 1;
            cap <= {mem_op, config_image_memory, all_pages_select, mem_page, read_margin_select};
        end
    end
    task check_v(input logic [31:0] a, input logic [31:0] e);
        total_checks++;
        if (a !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One bus write (w=1) or read (w=0); lets one edge pass before it drives
    task xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
        logic ta, tw, tr;
        bit ok;
        ok = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w && !slow_b;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (int k = 0; k < 50 && !ok; k++)
        begin
            @(negedge clk);
            ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = w ? s_axi_bresp : s_axi_rresp;
            @(posedge clk);
            if (ta)
            begin
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (tw)
                s_axi_wvalid <= 1'h0;
            if (tr)
            begin
                s_axi_bready <= 1'h0;
                s_axi_rready <= 1'h0;
                ok = 1;
            end
            else if (w && k == 3)
                s_axi_bready <= 1'h1;
        end
        if (!ok)
        begin
            n_errors++;
            print_verdict;
        end
    endtask
    // Control write, then count requests and compare the captured selection
    task cmd(input logic [31:0] d, input int n, input logic [8:0] c, input logic [8:0] m);
        int n0;
        n0 = n_req;
        xfer(1, `OCPS_ADDR_CONTROL, d);
        repeat (3) @(posedge clk);
        `CHK(n_req - n0, n);
        if (n > 0)
            `CHK(cap & m, c);
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task t_locked;
        xfer(0, `OCPS_ADDR_CONTROL, 0);
        `CHK(rd, 32'h2000);
        cmd(32'h01A1, 0, 9'h0, 9'h0);
        xfer(0, `OCPS_ADDR_CONTROL, 0);
        `CHK(rd, 32'h2021);
    endtask
    task t_array;
        logic [1:0] mg [4];
        mg = '{2'h0, 2'h2, 2'h3, 2'h2};
        xfer(1, `OCPS_ADDR_SECURITY_KEY, `OCPS_UNLOCK_KEY);
        for (int i = 0; i < 4; i++)
            cmd(32'h2100 | {mg[i], 6'h0} | i, 1, {4'h4, 3'(i), mg[i]}, 9'h1FF);
    endtask
    task t_image;
        for (int i = 0; i < 3; i++)
            cmd(32'h0400 | i, 1, {4'hE, 3'(i + 2), 2'h0}, 9'h1FF);
        cmd(32'h0403, 0, 9'h0, 9'h0);
        xfer(0, `OCPS_ADDR_STATUS, 0);
        `CHK(rd, 32'hA);
    endtask
    task t_bulk_margin;
        cmd(32'h21E0, 1, {4'h5, 3'h0, 2'h3}, 9'h1E3);
        cmd(32'h2140, 0, 9'h0, 9'h0);
        cmd(32'h2440, 0, 9'h0, 9'h0);
    endtask
    task t_flags;
        mem_fail <= 1'h1;
        cmd(32'h2201, 1, {4'h8, 3'h1, 2'h0}, 9'h1FF);
        mem_fail <= 1'h0;
        xfer(0, `OCPS_ADDR_STATUS, 0);
        `CHK(rd, 32'hE);
        xfer(1, `OCPS_ADDR_STATUS, 32'h6);
        xfer(0, `OCPS_ADDR_STATUS, 0);
        `CHK(rd, 32'h8);
    endtask
    task t_unmapped;
        slow_b <= 1'h1;
        xfer(1, 20'h10024, 32'h1);
        `CHK(rs, `OCPS_RESP_SLVERR);
        slow_b <= 1'h0;
        xfer(0, 20'h10024, 0);
        `CHK(rs, `OCPS_RESP_SLVERR);
        `CHK(rd, 32'h0);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        t_locked;
        t_array;
        t_image;
        t_bulk_margin;
        t_flags;
        t_unmapped;
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
